/* File: src/vfp_top.v */
/* validity filter path: request, capture, inversion, filtering, ram transfer, buffering.
   assumes fall-through queues, tables answering one clock late, all inputs synchronous. */
// Function
// - jam control forces requested baseline to 210
// - zero modulus: count 2048, baseline every 8
// - one validity stored per complex result word
// - storage baseline from dram queue, max 127
// - capture in math and divider, filter concurrently
// - mac into 8 banks within one microsecond
// - filtered value updates only at accumulation end
// - filtered in real half, raw in imaginary
// - divider result to validity ram, second half
// - channel 3 lsbs, pseudo-baseline upper 8 bits
// - queue output routed into result field
// - sub-baseline sent to accumulator and dram
// - output buffer written every validity cycle
// - both snapshot enables asserted together, once per output buffer write
// - subarray selects tap weights and clear entries
// - unnormalised mode stores unity, raw to dram
// - unity from equal numerator and denominator
// - sequencer counts 8 MHz step clock cycles
`timescale 1ns/1ps
`default_nettype none
`include "vfp_consts.vh"
module vfp_top (
  // clock and reset
  input wire mclk_in,
  input wire rst_b_in,
  input wire sequencer_step_clock_in,
  // control
  input wire run_in,
  input wire jam_in,
  input wire no_norm_in,
  output wire busy_out,
  output reg done_out,
  output wire [15:0] step_count_out,
  // queues
  input wire [13:0] modulus_subarray_queue_in,
  output reg modulus_subarray_queue_pop_out,
  input wire [7:0] acc_bl_queue_in,
  output reg acc_bl_queue_pop_out,
  input wire [7:0] dram_bl_queue_in,
  output reg dram_bl_queue_pop_out,
  output reg dram_bl_err_out,
  // long_term_accumulator request and validity
  output wire [7:0] lta_bl_out,
  output wire [10:0] lta_result_out,
  input wire val_valid_in,
  input wire [15:0] val_data_in,
  output wire val_ready_out,
  // coefficient bus and clear table
  output reg [5:0] table_addr_out,
  input wire [15:0] coef_in,
  input wire clac_in,
  input wire accum_done_in,
  output wire coef_bus_vram_out,
  // validity ram
  output reg vram_we_out,
  output reg [10:0] vram_addr_out,
  output reg [15:0] vram_data_out,
  // dram result field
  output wire [6:0] dram_bl_out,
  output wire [10:0] dram_result_out,
  output reg [15:0] dram_raw_out,
  // snapshot enables
  output reg snapshot_capture_enable_out,
  output reg snapshot_output_enable_out,
  // output buffer
  output wire out_valid_out,
  output wire [31:0] out_data_out,
  input wire out_ready_in
);
// ==================================
// step clock and cycle phase
reg step_d_ff;
reg [15:0] step_cnt_ff;
wire step_tick = sequencer_step_clock_in & ~step_d_ff;
wire second_half = step_cnt_ff[`VFP_HALF_BIT];
always @(posedge mclk_in)
begin
  if (!rst_b_in)
  begin
    step_d_ff <= 1'b0;
    step_cnt_ff <= 16'h0000;
  end
  else
  begin
    step_d_ff <= sequencer_step_clock_in;
    if (step_tick)
      step_cnt_ff <= step_cnt_ff + 16'h0001;
  end
end
assign step_count_out = step_cnt_ff;
assign coef_bus_vram_out = second_half;
// ==================================
// run control, queues and result counter
reg run_d_ff, busy_ff;
reg [11:0] limit_ff;
reg [2:0] subarray_ff;
reg [7:0] sub_bl_ff;
reg [6:0] dram_bl_ff;
reg [10:0] res_cnt_ff;
wire start = run_in & ~run_d_ff & ~busy_ff;
wire accept;
wire last_res = ({1'b0, res_cnt_ff} == limit_ff - 12'h001);
always @(posedge mclk_in)
begin
  if (!rst_b_in)
  begin
    run_d_ff <= 1'b0;
    busy_ff <= 1'b0;
    done_out <= 1'b0;
    limit_ff <= `VFP_FULL_COUNT;
    subarray_ff <= 3'h0;
    sub_bl_ff <= 8'h00;
    dram_bl_ff <= 7'h00;
    dram_bl_err_out <= 1'b0;
    res_cnt_ff <= 11'h000;
    modulus_subarray_queue_pop_out <= 1'b0;
    acc_bl_queue_pop_out <= 1'b0;
    dram_bl_queue_pop_out <= 1'b0;
  end
  else
  begin
    run_d_ff <= run_in;
    modulus_subarray_queue_pop_out <= start;
    dram_bl_queue_pop_out <= start;
    acc_bl_queue_pop_out <= start | (accept & (res_cnt_ff[2:0] == `VFP_CHAN_LAST));
    if (start)
    begin
      busy_ff <= 1'b1;
      done_out <= 1'b0;
      res_cnt_ff <= 11'h000;
      // zero modulus means a full 2048-result run
      limit_ff <= (modulus_subarray_queue_in[13:3] == 11'h000) ? `VFP_FULL_COUNT :
        {1'b0, modulus_subarray_queue_in[13:3]};
      subarray_ff <= modulus_subarray_queue_in[2:0];
      sub_bl_ff <= acc_bl_queue_in;
      dram_bl_ff <= dram_bl_queue_in[6:0];
      dram_bl_err_out <= (dram_bl_queue_in > `VFP_MAX_DRAM_BL);
    end
    else if (accept)
    begin
      res_cnt_ff <= res_cnt_ff + 11'h001;
      if (res_cnt_ff[2:0] == `VFP_CHAN_LAST)
        sub_bl_ff <= acc_bl_queue_in;
      if (last_res)
      begin
        busy_ff <= 1'b0;
        done_out <= 1'b1;
      end
    end
  end
end
assign busy_out = busy_ff;
assign lta_bl_out = jam_in ? `VFP_JAM_BL : sub_bl_ff;
assign lta_result_out = {sub_bl_ff, res_cnt_ff[2:0]};
assign dram_bl_out = dram_bl_ff;
// ==================================
// capture into math side and divider
reg [15:0] raw_ff, div_den_ff;
reg [10:0] res_lat_ff;
reg mac_act_ff, mac_v2_ff, pend_ff, div_act_ff, vpend_ff;
reg [2:0] mac_idx_ff, mac_i2_ff;
reg [1:0] buf_cnt_ff;
wire room = ({1'b0, buf_cnt_ff} + {2'b00, pend_ff}) < 3'h2;
reg [4:0] div_cnt_ff;
reg [29:0] div_sh_ff, div_q_ff;
reg [16:0] div_rem_ff;
assign val_ready_out = busy_ff & room & ~mac_act_ff & ~mac_v2_ff & ~div_act_ff & ~vpend_ff;
assign accept = val_valid_in & val_ready_out;
assign dram_result_out = res_lat_ff;
always @(posedge mclk_in)
begin
  if (!rst_b_in)
  begin
    raw_ff <= 16'h0000;
    res_lat_ff <= 11'h000;
    dram_raw_out <= 16'h0000;
  end
  else if (accept)
  begin
    raw_ff <= val_data_in;
    res_lat_ff <= {sub_bl_ff, res_cnt_ff[2:0]};
    dram_raw_out <= val_data_in;
  end
end
// ==================================
// divider: quotient = (num << frac) / den, one bit per clock
wire [16:0] div_try = {div_rem_ff[15:0], div_sh_ff[29]};
wire div_ge = (div_try >= {1'b0, div_den_ff});
always @(posedge mclk_in)
begin
  if (!rst_b_in)
  begin
    div_act_ff <= 1'b0;
    div_cnt_ff <= 5'h00;
    div_sh_ff <= 30'h0000_0000;
    div_rem_ff <= 17'h0_0000;
    div_den_ff <= 16'h0000;
    div_q_ff <= 30'h0000_0000;
    vpend_ff <= 1'b0;
    vram_we_out <= 1'b0;
    vram_addr_out <= 11'h000;
    vram_data_out <= 16'h0000;
  end
  else
  begin
    vram_we_out <= 1'b0;
    if (accept)
    begin
      // unity: numerator equals denominator
      div_sh_ff <= no_norm_in ? {val_data_in, {`VFP_FRAC_BITS{1'b0}}} :
        {`VFP_SAT, {`VFP_FRAC_BITS{1'b0}}};
      div_den_ff <= val_data_in;
      div_rem_ff <= 17'h0_0000;
      div_q_ff <= 30'h0000_0000;
      div_cnt_ff <= `VFP_DIV_STEPS;
      div_act_ff <= 1'b1;
    end
    else if (div_act_ff)
    begin
      div_rem_ff <= div_ge ? (div_try - {1'b0, div_den_ff}) : div_try;
      div_sh_ff <= {div_sh_ff[28:0], 1'b0};
      div_q_ff <= {div_q_ff[28:0], div_ge};
      div_cnt_ff <= div_cnt_ff - 5'h01;
      if (div_cnt_ff == `VFP_DIV_LAST)
      begin
        div_act_ff <= 1'b0;
        vpend_ff <= 1'b1;
      end
    end
    else if (vpend_ff & second_half)
    begin
      // bus is free of tap weights in the imaginary half
      vpend_ff <= 1'b0;
      vram_we_out <= 1'b1;
      vram_addr_out <= res_lat_ff;
      vram_data_out <= (div_den_ff == 16'h0000 || div_q_ff[29:16] != 14'h0000) ? `VFP_SAT :
        div_q_ff[15:0];
    end
  end
end
// ==================================
// multiply-accumulate into 8 banks, table answers one clock later
reg [31:0] acc_mem [0:7];
reg [15:0] filt_ff;
wire [31:0] prod = raw_ff * coef_in;
wire [31:0] sum = (clac_in ? 32'h0000_0000 : acc_mem[mac_i2_ff]) + prod;
wire [15:0] nxt_filt = (mac_v2_ff & accum_done_in) ? sum[29:14] : filt_ff;
integer k;
always @(posedge mclk_in)
begin
  if (!rst_b_in)
  begin
    mac_act_ff <= 1'b0;
    mac_idx_ff <= 3'h0;
    mac_v2_ff <= 1'b0;
    mac_i2_ff <= 3'h0;
    table_addr_out <= 6'h00;
    filt_ff <= 16'h0000;
    for (k = 0; k < 8; k = k + 1)
      acc_mem[k] <= 32'h0000_0000;
  end
  else
  begin
    mac_v2_ff <= mac_act_ff;
    mac_i2_ff <= mac_idx_ff;
    if (accept)
    begin
      mac_act_ff <= 1'b1;
      mac_idx_ff <= 3'h0;
      table_addr_out <= {subarray_ff, 3'h0};
    end
    else if (mac_act_ff)
    begin
      if (mac_idx_ff == `VFP_LAST_BANK)
        mac_act_ff <= 1'b0;
      else
      begin
        mac_idx_ff <= mac_idx_ff + 3'h1;
        table_addr_out <= {subarray_ff, mac_idx_ff + 3'h1};
      end
    end
    if (mac_v2_ff)
    begin
      acc_mem[mac_i2_ff] <= sum;
      if (accum_done_in)
        filt_ff <= sum[29:14];
    end
  end
end
// ==================================
// two-entry output buffer and snapshot enables
reg [31:0] buf_mem [0:1];
reg wr_ptr_ff, rd_ptr_ff;
wire push = mac_v2_ff & ~mac_act_ff;
wire pop = out_ready_in & (buf_cnt_ff != 2'h0);
assign out_valid_out = (buf_cnt_ff != 2'h0);
assign out_data_out = buf_mem[rd_ptr_ff];
always @(posedge mclk_in)
begin
  if (!rst_b_in)
  begin
    pend_ff <= 1'b0;
    buf_cnt_ff <= 2'h0;
    wr_ptr_ff <= 1'b0;
    rd_ptr_ff <= 1'b0;
    buf_mem[0] <= 32'h0000_0000;
    buf_mem[1] <= 32'h0000_0000;
    snapshot_capture_enable_out <= 1'b0;
    snapshot_output_enable_out <= 1'b0;
  end
  else
  begin
    snapshot_capture_enable_out <= push;
    snapshot_output_enable_out <= push;
    pend_ff <= accept | (pend_ff & ~push);
    if (push)
    begin
      // written once per accepted word, even when no filtered result is due
      buf_mem[wr_ptr_ff] <= {nxt_filt, raw_ff};
      wr_ptr_ff <= ~wr_ptr_ff;
    end
    if (pop)
      rd_ptr_ff <= ~rd_ptr_ff;
    if (push & ~pop)
      buf_cnt_ff <= buf_cnt_ff + 2'h1;
    else if (pop & ~push)
      buf_cnt_ff <= buf_cnt_ff - 2'h1;
  end
end
endmodule // vfp_top
`default_nettype wire

/* File: src/vfp_consts.vh */
/*
  constants of the validity filter path: addresses, field layout, counts.
  assumes inclusion by vfp_top.v only.
*/
`ifndef VFP_CONSTS_VH
`define VFP_CONSTS_VH
// ==================================
// addressing
`define VFP_JAM_BL 8'hd2
`define VFP_MAX_DRAM_BL 8'h7f
`define VFP_FULL_COUNT 12'h0800
`define VFP_CHAN_LAST 3'h7
// ==================================
// filter banks and divider
`define VFP_LAST_BANK 3'h7
`define VFP_FRAC_BITS 14
`define VFP_DIV_STEPS 5'h1e
`define VFP_DIV_LAST 5'h01
`define VFP_SAT 16'hffff
// ==================================
// timing: 8 MHz steps, 2 usec validity cycle
`define VFP_STEP_NS 125
`define VFP_CYCLE_NS 2000
`define VFP_STEPS_PER_CYCLE (`VFP_CYCLE_NS / `VFP_STEP_NS)
`define VFP_HALF_BIT 3
`endif

/* File: tb/vfp_top_asserts.sv */
/* port checker for vfp_top.
   assumes a bind into vfp_top and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module vfp_chk (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // inputs
  input wire logic jam_in,
  input wire logic val_valid_in,
  // outputs
  input wire logic busy_out,
  input wire logic modulus_subarray_queue_pop_out,
  input wire logic dram_bl_queue_pop_out,
  input wire logic [7:0] lta_bl_out,
  input wire logic [10:0] lta_result_out,
  input wire logic val_ready_out,
  input wire logic [5:0] table_addr_out,
  input wire logic coef_bus_vram_out,
  input wire logic vram_we_out,
  input wire logic snapshot_capture_enable_out,
  input wire logic snapshot_output_enable_out
);
  // ==========
  // assertions
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  wire logic take_w = val_valid_in && val_ready_out;
  jam_force_a: assert property (jam_in |-> lta_bl_out == 8'hd2)
    else $error("jam baseline wrong");
  field_split_a: assert property (!jam_in |-> lta_result_out[10:3] == lta_bl_out)
    else $error("result field wrong");
  bank_sweep_a: assert property (take_w |=> table_addr_out[2:0] == 3'h0 ##7
    table_addr_out[2:0] == 3'h7)
    else $error("bank sweep wrong");
  hold_off_a: assert property (take_w |=> !val_ready_out [*8])
    else $error("validity taken too soon");
  vram_half_a: assert property (vram_we_out |-> $past(coef_bus_vram_out))
    else $error("ram write in first half");
  snap_pair_a: assert property (snapshot_capture_enable_out == snapshot_output_enable_out)
    else $error("snapshot enables apart");
  start_pop_a: assert property ($rose(busy_out) |->
    modulus_subarray_queue_pop_out && dram_bl_queue_pop_out)
    else $error("queues not popped");
  reset_clear_a: assert property (disable iff (1'b0) !rst_b_in |=>
    !vram_we_out && !busy_out && !snapshot_capture_enable_out)
    else $error("state left after reset");
  take_c: cover property (take_w);
  write_c: cover property (vram_we_out);
  jam_c: cover property (jam_in && busy_out);
endmodule // vfp_chk
bind vfp_top vfp_chk i_chk (.*);
`default_nettype wire

/* File: tb/vfp_lta_model.sv */
/* upstream accumulator model: validity source and step clock.
   assumes the bench raises send_in only while no word is pending. */
`timescale 1ns/1ps
`default_nettype none
module vfp_lta_model (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // bench control
  input wire logic send_in,
  input wire logic [15:0] word_in,
  // validity handshake
  output logic val_valid_out,
  output logic [15:0] val_data_out,
  input wire logic val_ready_in,
  // step clock
  output logic step_clk_out
);
  logic [2:0] ph_ff;
  // ==========
  // free running step clock, halves of 6 and 7 cycles
  always @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      ph_ff <= 3'h0;
      step_clk_out <= 1'b0;
    end
    else if (ph_ff == 3'h5 + {2'h0, step_clk_out})
    begin
      ph_ff <= 3'h0;
      step_clk_out <= !step_clk_out;
    end
    else
      ph_ff <= ph_ff + 3'h1;
  end
  // ==========
  // one word held until taken
  always @(posedge mclk_in)
    if (!rst_b_in)
    begin
      val_valid_out <= 1'b0;
      val_data_out <= 16'h0000;
    end
    else if (val_valid_out && val_ready_in)
    begin
      val_valid_out <= 1'b0;
      val_data_out <= ~val_data_out;
    end
    else if (send_in)
    begin
      val_valid_out <= 1'b1;
      val_data_out <= word_in;
    end
endmodule // vfp_lta_model
`default_nettype wire

/* File: tb/tb_vfp_top.sv */
/* self-checking bench for vfp_top.
   assumes the accumulator model and the bound checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
module tb_vfp_top;
  logic mclk_in, rst_b_in, sequencer_step_clock_in, run_in, jam_in, no_norm_in, busy_out;
  logic done_out, modulus_subarray_queue_pop_out, acc_bl_queue_pop_out, dram_bl_queue_pop_out;
  logic dram_bl_err_out, val_valid_in, val_ready_out, clac_in, accum_done_in, coef_bus_vram_out;
  logic vram_we_out, snapshot_capture_enable_out, snapshot_output_enable_out, out_valid_out;
  logic out_ready_in, send, took = 1'b0;
  logic [15:0] step_count_out, val_data_in, coef_in, vram_data_out, dram_raw_out, word, filt;
  logic [15:0] step_base;
  logic [13:0] modulus_subarray_queue_in;
  logic [7:0] acc_bl_queue_in, dram_bl_queue_in, lta_bl_out;
  logic [10:0] lta_result_out, vram_addr_out, dram_result_out;
  logic [6:0] dram_bl_out;
  logic [5:0] table_addr_out;
  logic [31:0] out_data_out;
  logic [31:0] exp_q[$];
  int n_errors = 0, checks_done = 0, cyc = 0, pops = 0, snaps = 0, snap_base = 0;
  // rows: no normalise, accumulate end, raw word, expected validity ram word
  logic [33:0] rows [8] = '{{2'b00, 16'hffff, 16'h4000}, {2'b00, 16'h8000, 16'h7fff},
    {2'b00, 16'h4000, 16'hffff}, {2'b10, 16'h1234, 16'h4000}, {2'b01, 16'h1000, 16'hffff},
    {2'b11, 16'h0002, 16'h4000}, {2'b00, 16'h0001, 16'hffff}, {2'b00, 16'hc000, 16'h5555}};
  vfp_top i_dut (.*);
  vfp_lta_model i_lta (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .send_in(send), .word_in(word),
    .val_valid_out(val_valid_in), .val_data_out(val_data_in), .val_ready_in(val_ready_out),
    .step_clk_out(sequencer_step_clock_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task close_out;
    if (n_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // ==========
  // monitor and timeout
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      close_out;
    end
    else
    begin
      pops += acc_bl_queue_pop_out;
      snaps += snapshot_capture_enable_out;
      if (took && !jam_in)
        chk(32'(table_addr_out[5:3]), 32'h0000_0005);
      took = val_valid_in && val_ready_out;
      if (took && !jam_in)
        chk(32'(lta_result_out[10:3]), 32'h0000_002a);
      if (out_valid_out && out_ready_in)
        chk(out_data_out, exp_q.pop_front());
    end
  end
  // ==========
  // main sequence
  initial
  begin
    {rst_b_in, run_in, jam_in, no_norm_in, send, clac_in, accum_done_in, out_ready_in} = 8'h00;
    {word, filt} = 32'h0000_0000;
    coef_in = 16'h4000;
    modulus_subarray_queue_in = 14'h0045;
    acc_bl_queue_in = 8'h2a;
    dram_bl_queue_in = 8'h7f;
    repeat (10) @(negedge mclk_in);
    chk(32'(busy_out), 32'h0000_0000);
    rst_b_in = 1'b1;
    run_in = 1'b1;
    foreach (rows[i])
    begin
      {no_norm_in, clac_in, word} = rows[i][33:16];
      accum_done_in = clac_in;
      out_ready_in = (i > 1);
      send = 1'b1;
      if (clac_in)
        filt = word;
      exp_q.push_back({filt, word});
      @(negedge mclk_in);
      send = 1'b0;
      while (!vram_we_out)
        @(negedge mclk_in);
      chk(32'(vram_data_out), 32'(rows[i][15:0]));
      chk(32'(dram_raw_out), 32'(word));
      chk(32'(vram_addr_out), 32'h0000_0150 + 32'(i));
      chk(32'(dram_result_out), 32'h0000_0150 + 32'(i));
    end
    out_ready_in = 1'b1;
    while (exp_q.size() > 0)
      @(negedge mclk_in);
    chk(32'(done_out), 32'h0000_0001);
    chk(32'(pops), 32'h0000_0002);
    chk(32'(snaps), 32'h0000_0008);
    chk(32'(dram_bl_out), 32'h0000_007f);
    jam_in = 1'b1;
    dram_bl_queue_in = 8'h80;
    run_in = 1'b0;
    @(negedge mclk_in);
    run_in = 1'b1;
    repeat (3) @(negedge mclk_in);
    chk(32'(lta_bl_out), 32'h0000_00d2);
    chk(32'(dram_bl_err_out), 32'h0000_0001);
    send = 1'b1;
    @(negedge mclk_in);
    send = 1'b0;
    repeat (4) @(negedge mclk_in);
    rst_b_in = 1'b0;
    @(negedge mclk_in);
    rst_b_in = 1'b1;
    snap_base = snaps;
    repeat (10) @(negedge mclk_in);
    step_base = step_count_out;
    repeat (390) @(negedge mclk_in);
    chk(32'(step_count_out - step_base), 32'h0000_001e);
    chk(32'(snaps - snap_base), 32'h0000_0000);
    close_out;
  end
endmodule // tb_vfp_top
`default_nettype wire
